/* rtl/hdpc_corrector.sv */
// Phase offset corrector, loop, oscillator control and lock indicator
`timescale 1ns/100ps
module hdpc_corrector #(
	parameter int STORE_CYCLES = hdpc_pkg::STORE_CYC,
	parameter int HOLD_LOCK_PRI_CYCLES = hdpc_pkg::HOLD_LOCK_PRI_CYC,
	parameter int HOLD_LOCK_SEC_CYCLES = hdpc_pkg::HOLD_LOCK_SEC_CYC,
	parameter int LOCK_QUAL_CYCLES = hdpc_pkg::LOCK_QUAL_CYC,
	parameter logic [31:0] LOCK_WINDOW_WIDTH = hdpc_pkg::LOCK_WINDOW
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire hdpc_pkg::hdpc_refs_type i_refs,
	input wire logic [1:0] i_reference_sel,
	input wire logic [1:0] i_operating_mode_sel,
	input wire logic i_hitless_return_sel,
	input wire logic i_secondary_role_sel,
	input wire logic i_phase_offset_clear_n,
	input wire logic i_ref_fail,
	input wire logic i_ref_is_8khz,
	output logic o_lock,
	output hdpc_pkg::hdpc_status_type o_status,
	output logic o_dco_clk,
	output logic [31:0] o_freq_word,
	output logic [31:0] o_phase_offset
);
	import hdpc_pkg::*;

	hdpc_regs_type r_reg;
	hdpc_regs_type r_next;
	logic ref_now;
	logic ref_edge;
	logic clear_now;
	logic want_normal;
	logic [4:0] shift;
	logic signed [31:0] step;
	logic signed [31:0] corr;
	logic signed [31:0] err_abs;
	logic [CNT_W-1:0] hold_limit;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_next = r_reg;
		// Two-stage synchronisers, first stage feeds only the second
		r_next.clr_s1 = i_phase_offset_clear_n;
		r_next.clr_s2 = r_reg.clr_s1;
		r_next.hrs_s1 = i_hitless_return_sel;
		r_next.hrs_s2 = r_reg.hrs_s1;
		r_next.mode_s1 = i_operating_mode_sel;
		r_next.mode_s2 = r_reg.mode_s1;

		// Pulses shorter than the minimum width are ignored
		if (r_reg.clr_s2) begin
			r_next.clr_cnt = 3'h0;
		end else if (r_reg.clr_cnt != 3'(CLR_MIN_CYC)) begin
			r_next.clr_cnt = r_reg.clr_cnt + 3'h1;
		end
		clear_now = (r_reg.clr_cnt == 3'(CLR_MIN_CYC));

		unique case (i_reference_sel)
			2'h1: ref_now = i_refs.secondary_ref_in;
			2'h2: ref_now = i_refs.tertiary_ref_in;
			default: ref_now = i_refs.primary_ref_in;
		endcase
		ref_edge = ref_now & ~r_reg.ref_prev;
		r_next.ref_prev = ref_now;
		r_next.ref_sel_prev = i_reference_sel;

		// Wide loop in secondary role, narrowed further for 8 kHz references
		if (!i_secondary_role_sel) begin
			shift = SHIFT_PRI;
			step = STEP_PRI;
		end else begin
			shift = i_ref_is_8khz ? SHIFT_8K : SHIFT_SEC;
			step = STEP_SEC;
		end
		corr = r_reg.err >>> shift;
		if (corr > step) begin
			corr = step;
		end else if (corr < -step) begin
			corr = -step;
		end
		err_abs = r_reg.err[31] ? -r_reg.err : r_reg.err;
		hold_limit = i_secondary_role_sel ? CNT_W'(HOLD_LOCK_SEC_CYCLES - 1) : CNT_W'(HOLD_LOCK_PRI_CYCLES - 1);
		want_normal = (r_reg.mode_s2 == MODE_NORMAL || r_reg.mode_s2 == MODE_AUTO) && !i_ref_fail;

		// Freerun ignores the frequency word entirely
		r_next.dco_phase = r_reg.dco_phase + ((r_reg.st == ST_FREERUN) ? NOM_INC : r_reg.freq_word);
		r_next.dco_clk = r_reg.dco_phase[31];

		unique case (r_reg.st)
			ST_HOLDOVER, ST_FREERUN: begin
				if (r_reg.st == ST_HOLDOVER && r_reg.hold_cnt != hold_limit) begin
					r_next.hold_cnt = r_reg.hold_cnt + CNT_W'(1);
				end
				if (r_reg.st == ST_HOLDOVER && r_reg.hold_cnt == hold_limit) begin
					r_next.lock = 1'b0;
					r_next.lock_cnt = '0;
				end
				if (r_reg.mode_s2 == MODE_FREERUN) begin
					r_next.st = ST_FREERUN;
					r_next.lock = 1'b0;
					r_next.lock_cnt = '0;
				end else if (want_normal) begin
					// Low select keeps the old gap so phase walks back
					r_next.st = r_reg.hrs_s2 ? ST_MEASURE : ST_NORMAL;
				end else if (r_reg.mode_s2 == MODE_HOLDOVER) begin
					r_next.st = ST_HOLDOVER;
				end
			end
			ST_NORMAL, ST_MEASURE: begin
				if (r_reg.mode_s2 == MODE_FREERUN) begin
					r_next.st = ST_FREERUN;
					r_next.lock = 1'b0;
					r_next.lock_cnt = '0;
				end else if (!want_normal) begin
					// Older slot is 26 to 52 ms old; phase continues without a step
					r_next.st = ST_HOLDOVER;
					r_next.hold_cnt = '0;
					r_next.freq_word = r_reg.slot_ptr ? r_reg.slot1 : r_reg.slot0;
				end else if (r_reg.st == ST_MEASURE) begin
					if (ref_edge) begin
						r_next.offset = r_reg.dco_phase;
						r_next.st = ST_NORMAL;
					end
				end else if (i_reference_sel != r_reg.ref_sel_prev) begin
					r_next.st = ST_MEASURE;
				end else begin
					if (ref_edge) begin
						// Wrapping difference picks the shortest way round
						r_next.err = $signed(r_reg.dco_phase - r_reg.offset);
						r_next.freq_word = r_reg.freq_word + 32'(corr);
					end
					if (err_abs >= $signed(LOCK_WINDOW_WIDTH)) begin
						r_next.lock_cnt = '0;
					end else if (r_reg.lock_cnt != CNT_W'(LOCK_QUAL_CYCLES)) begin
						r_next.lock_cnt = r_reg.lock_cnt + CNT_W'(1);
					end
					if (r_reg.lock_cnt == CNT_W'(LOCK_QUAL_CYCLES)) begin
						r_next.lock = 1'b1;
					end
					if (r_reg.lock) begin
						if (r_reg.store_cnt == CNT_W'(STORE_CYCLES - 1)) begin
							r_next.store_cnt = '0;
							r_next.slot_ptr = ~r_reg.slot_ptr;
							if (r_reg.slot_ptr) begin
								r_next.slot1 = r_reg.freq_word;
							end else begin
								r_next.slot0 = r_reg.freq_word;
							end
						end else begin
							r_next.store_cnt = r_reg.store_cnt + CNT_W'(1);
						end
					end
				end
			end
		endcase

		// Held-low clear keeps the gap at zero, so switches are not hitless
		if (clear_now || i_secondary_role_sel) begin
			r_next.offset = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			r_reg <= '0;
			r_reg.clr_s1 <= 1'b1;
			r_reg.clr_s2 <= 1'b1;
			r_reg.st <= ST_HOLDOVER;
			r_reg.freq_word <= NOM_INC;
			r_reg.slot0 <= NOM_INC;
			r_reg.slot1 <= NOM_INC;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_lock = r_reg.lock;
	assign o_dco_clk = r_reg.dco_clk;
	assign o_freq_word = r_reg.freq_word;
	assign o_phase_offset = r_reg.offset;
	assign o_status.normal = r_reg.st[1];
	assign o_status.holdover = r_reg.st[0];
	assign o_status.freerun = r_reg.st[2];
	assign o_status.measuring = r_reg.st[3];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_clear_held;
		!r_reg.clr_s2 [*4] ##1 !r_reg.clr_s2;
	endsequence

	sequence s_enter_freerun;
		r_reg.st != ST_FREERUN ##1 r_reg.st == ST_FREERUN;
	endsequence

	a_clear_zeroes: assert property (s_clear_held |=> r_reg.offset == 32'h0000_0000)
		else $error("offset not cleared after held clear");
	a_role_clears: assert property (i_secondary_role_sel |=> r_reg.offset == 32'h0000_0000)
		else $error("secondary role did not clear offset");
	a_freerun_unlock: assert property (s_enter_freerun |-> !o_lock)
		else $error("lock high in freerun");
	a_measure_store: assert property (r_reg.st == ST_MEASURE && ref_edge && want_normal && !clear_now
		&& !i_secondary_role_sel && r_reg.mode_s2 != MODE_FREERUN |=> r_reg.offset == $past(r_reg.dco_phase))
		else $error("gap not stored on measurement");
	a_no_update_return: assert property (r_reg.st == ST_HOLDOVER && r_reg.mode_s2 != MODE_FREERUN && want_normal
		&& !r_reg.hrs_s2 && !clear_now && !i_secondary_role_sel |=> r_reg.st == ST_NORMAL
		&& r_reg.offset == $past(r_reg.offset))
		else $error("gap changed on plain return");
	a_free_rate: assert property (r_reg.st == ST_FREERUN |=> r_reg.dco_phase == $past(r_reg.dco_phase) + NOM_INC)
		else $error("freerun oscillator corrected");
	a_slope_cap: assert property (r_reg.st == ST_NORMAL && !i_secondary_role_sel && want_normal
		&& r_reg.mode_s2 != MODE_FREERUN |=> (r_reg.freq_word - $past(r_reg.freq_word) <= STEP_PRI)
		|| ($past(r_reg.freq_word) - r_reg.freq_word <= STEP_PRI))
		else $error("frequency step above slope limit");
	a_lock_qualified: assert property ($rose(o_lock) |-> $past(r_reg.lock_cnt) == CNT_W'(LOCK_QUAL_CYCLES))
		else $error("lock rose without qualification");
	a_hold_keeps_lock: assert property (r_reg.st == ST_HOLDOVER && o_lock && r_reg.hold_cnt != hold_limit
		&& r_reg.mode_s2 != MODE_FREERUN |=> o_lock)
		else $error("lock dropped early in holdover");
	a_hold_freq: assert property (r_reg.st == ST_NORMAL ##1 r_reg.st == ST_HOLDOVER
		|-> r_reg.freq_word == ($past(r_reg.slot_ptr) ? $past(r_reg.slot1) : $past(r_reg.slot0)))
		else $error("holdover frequency not from older slot");

endmodule

/* rtl/hdpc_pkg.sv */
// Constants, state and carrier types of the hitless phase corrector
//
// How it works
// - On reference switch or hitless return, measure and store feedback-to-reference phase gap.
// - Virtual reference is the selected reference shifted by the stored gap.
// - Offset-clear held low at least 15 ns zeroes the gap; outputs realign.
// - Realignment rate bounded by bandwidth and slope limit; shortest phase direction.
// - Offset-clear held low keeps outputs aligned; switches are then not hitless.
// - Hitless-return select governs return from freerun or holdover to normal.
// - Hitless-return low: gap not updated on return; phase drifts back.
// - Hitless-return high: gap recomputed on return to normal.
// - Reference switching is hitless unless offset-clear is held low or secondary role is selected.
// - No phase step entering holdover; at most 13 ns step on re-measured return.
// - Phase detector compares virtual reference with feedback; lock detector taps error.
// - Limiter caps output phase slope; limit chosen by secondary-role select.
// - Secondary role clears the gap, wide bandwidth, 9.5 ms/s slope limit.
// - First-order loop: 1.8 Hz primary, 922 Hz secondary, 58 Hz for 8 kHz.
// - Normal mode: oscillator locked in frequency and phase to selected reference.
// - Holdover frequency taken from sample stored 26 to 52 ms earlier.
// - While locked in normal, store frequency word every 26 ms, two alternating slots.
// - Freerun: oscillator runs from master clock alone, no correction.
// - Lock asserts only after error stays inside window for qualification time.
// - Entering holdover, lock stays high 1 s primary, 0.1 s secondary, then drops.
// - After lock drops, it stays low at least one full qualification time.
// - Entering freerun drops lock immediately.
// - State machine driven by mode, reference and hitless-return selects.
package hdpc_pkg;

	localparam int CLK_HZ = 250_000_000;
	localparam int CLK_PERIOD_PS = 4000;

	localparam int CLR_MIN_NS = 15;
	localparam int CLR_MIN_CYC = (CLR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STORE_MS = 26;
	localparam int STORE_CYC = STORE_MS * (CLK_HZ / 1000);
	localparam int HOLD_LOCK_PRI_MS = 1000;
	localparam int HOLD_LOCK_PRI_CYC = HOLD_LOCK_PRI_MS * (CLK_HZ / 1000);
	localparam int HOLD_LOCK_SEC_MS = 100;
	localparam int HOLD_LOCK_SEC_CYC = HOLD_LOCK_SEC_MS * (CLK_HZ / 1000);
	localparam int LOCK_QUAL_MS = 1000;
	localparam int LOCK_QUAL_CYC = LOCK_QUAL_MS * (CLK_HZ / 1000);
	localparam int CNT_W = 28;

	// Operating mode select codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_HOLDOVER = 2'h1;
	localparam logic [1:0] MODE_FREERUN = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;

	// Nominal phase increment: 2.048 MHz out of a 250 MHz clock, 32-bit accumulator
	localparam logic [31:0] NOM_INC = 32'h0218_DEF4;
	localparam logic [31:0] LOCK_WINDOW = 32'h0100_0000;

	// Phase slope limits in parts per billion
	localparam longint SLOPE_PRI_PPB = 61_000;
	localparam longint SLOPE_SEC_PPB = 9_500_000;
	localparam logic [31:0] STEP_PRI = 32'(longint'(NOM_INC) * SLOPE_PRI_PPB / 1_000_000_000);
	localparam logic [31:0] STEP_SEC = 32'(longint'(NOM_INC) * SLOPE_SEC_PPB / 1_000_000_000);

	// Loop bandwidths in mHz and the gain shifts that realise them
	localparam int BW_PRI_MHZ = 1_800;
	localparam int BW_SEC_MHZ = 922_000;
	localparam int BW_8K_MHZ = 58_000;
	localparam logic [4:0] SHIFT_PRI = 5'h10;
	localparam logic [4:0] SHIFT_SEC = 5'h07;
	localparam logic [4:0] SHIFT_8K = 5'h0B;

	typedef enum logic [3:0] {
		ST_HOLDOVER = 4'h1,
		ST_NORMAL = 4'h2,
		ST_FREERUN = 4'h4,
		ST_MEASURE = 4'h8
	} hdpc_state_type;

	typedef struct packed {
		logic primary_ref_in;
		logic secondary_ref_in;
		logic tertiary_ref_in;
	} hdpc_refs_type;

	typedef struct packed {
		logic normal;
		logic holdover;
		logic freerun;
		logic measuring;
	} hdpc_status_type;

	typedef struct packed {
		logic clr_s1;
		logic clr_s2;
		logic hrs_s1;
		logic hrs_s2;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic [2:0] clr_cnt;
		hdpc_state_type st;
		logic ref_prev;
		logic [1:0] ref_sel_prev;
		logic [31:0] offset;
		logic [31:0] dco_phase;
		logic [31:0] freq_word;
		logic signed [31:0] err;
		logic [31:0] slot0;
		logic [31:0] slot1;
		logic slot_ptr;
		logic [CNT_W-1:0] store_cnt;
		logic lock;
		logic [CNT_W-1:0] lock_cnt;
		logic [CNT_W-1:0] hold_cnt;
		logic dco_clk;
	} hdpc_regs_type;

endpackage

/* testbench/hdpc_ref_model.sv */
// Reference clock model: three staggered square waves in the master clock domain
`timescale 1ns/100ps
module hdpc_ref_model #(
	parameter int HALF_CYCLES = 61
) (
	input wire logic i_clk,
	input wire logic i_run,
	output hdpc_pkg::hdpc_refs_type o_refs
);
	import hdpc_pkg::*;
	logic [2:0] ref_reg = 3'h0;
	int cnt = 0;
	assign o_refs = ref_reg;
	// Stagger so a reference switch sees a real phase gap
	always @(posedge i_clk) begin
		cnt <= (cnt == HALF_CYCLES - 1) ? 0 : cnt + 1;
		for (int i = 0; i < 3; i++) begin
			if (i_run && cnt == i * 17) begin
				ref_reg[i] <= ~ref_reg[i];
			end
		end
	end
endmodule

/* testbench/hdpc_corrector_test.sv */
// Self-checking bench for the hitless phase corrector
`timescale 1ns/100ps
module hdpc_corrector_test;
	import hdpc_pkg::*;
	localparam int LQ = 30;
	localparam int HP = 200;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	hdpc_refs_type refs;
	logic [1:0] rsel = 2'h0;
	logic [1:0] msel = 2'h0;
	logic hrs = 1'b0;
	logic role = 1'b0;
	logic clr_n = 1'b1;
	logic fail = 1'b0;
	logic lock;
	hdpc_status_type st;
	logic [31:0] fw;
	logic [31:0] ofs;
	logic [31:0] snap;
	logic dco;
	logic dco_d;
	int rises;
	int n_fail = 0;
	int cmp_count = 0;
	int k;
	always #2 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////
	hdpc_ref_model #(.HALF_CYCLES(61)) u_refs (.i_clk(i_clk), .i_run(1'b1), .o_refs(refs));
	hdpc_corrector #(.STORE_CYCLES(50), .HOLD_LOCK_PRI_CYCLES(HP), .HOLD_LOCK_SEC_CYCLES(40),
		.LOCK_QUAL_CYCLES(LQ)) u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_refs(refs),
		.i_reference_sel(rsel), .i_operating_mode_sel(msel), .i_hitless_return_sel(hrs),
		.i_secondary_role_sel(role), .i_phase_offset_clear_n(clr_n), .i_ref_fail(fail),
		.i_ref_is_8khz(1'b0), .o_lock(lock), .o_status(st), .o_dco_clk(dco),
		.o_freq_word(fw), .o_phase_offset(ofs));
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Settled sampling point: 1 ns after the last of the n rising edges
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wait_st(input int b);
		for (k = 0; k < 3000 && st[b] !== 1'b1; k++) step(1);
		if (k == 3000) begin
			n_fail++;
			wrap_up();
		end
	endtask
	// Counts cycles until lock reaches the given level
	task automatic wait_lock(input logic v);
		for (k = 0; k < 5000 && lock !== v; k++) step(1);
		if (k == 5000) begin
			n_fail++;
			wrap_up();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		step(2);
		check(32'(st), 32'h0000_0004);
		check(fw, NOM_INC);
		check(ofs, 32'h0000_0000);
		check(32'(lock), 32'h0000_0000);
		@(posedge i_clk) i_reset <= 1'b0;
		wait_st(3);
		wait_lock(1'b1);
		check(32'(k >= LQ), 32'h0000_0001);
		$display("Test lock qualification done");
		// Hitless select needs its synchroniser settled before the return
		@(posedge i_clk) begin
			fail <= 1'b1;
			hrs <= 1'b1;
		end
		wait_st(2);
		snap = fw;
		wait_lock(1'b0);
		check(32'(k >= HP - 2 && k <= HP + 2), 32'h0000_0001);
		check(fw, snap);
		@(posedge i_clk) fail <= 1'b0;
		wait_st(0);
		check(32'(st.measuring), 32'h0000_0001);
		wait_st(3);
		wait_lock(1'b1);
		check(32'(k >= LQ), 32'h0000_0001);
		$display("Test holdover and hitless return done");
		@(posedge i_clk) rsel <= 2'h1;
		wait_st(0);
		check(32'(st.measuring), 32'h0000_0001);
		wait_st(3);
		snap = ofs;
		// Too short to count as a clear
		@(posedge i_clk) clr_n <= 1'b0;
		@(posedge i_clk) clr_n <= 1'b1;
		step(10);
		check(ofs, snap);
		@(posedge i_clk) clr_n <= 1'b0;
		step(10);
		check(ofs, 32'h0000_0000);
		@(posedge i_clk) rsel <= 2'h2;
		step(300);
		check(ofs, 32'h0000_0000);
		@(posedge i_clk) clr_n <= 1'b1;
		$display("Test offset clear done");
		@(posedge i_clk) rsel <= 2'h0;
		wait_st(3);
		@(posedge i_clk) role <= 1'b1;
		step(4);
		check(ofs, 32'h0000_0000);
		@(posedge i_clk) role <= 1'b0;
		$display("Test secondary role done");
		@(posedge i_clk) msel <= MODE_FREERUN;
		wait_st(1);
		check(32'(lock), 32'h0000_0000);
		snap = fw;
		step(100);
		check(fw, snap);
		// Nominal increment gives just under ten oscillator periods in 1220 cycles
		rises = 0;
		dco_d = dco;
		for (int i = 0; i < 1220; i++) begin
			step(1);
			if (dco === 1'b1 && dco_d === 1'b0) begin
				rises++;
			end
			dco_d = dco;
		end
		check(32'(rises >= 9 && rises <= 11), 32'h0000_0001);
		@(posedge i_clk) msel <= MODE_HOLDOVER;
		wait_st(2);
		check(32'(st), 32'h0000_0004);
		@(posedge i_clk) msel <= MODE_AUTO;
		wait_st(3);
		check(32'(st), 32'h0000_0008);
		$display("Test freerun and manual holdover done");
		wrap_up();
	end
endmodule
